// ==== bench/cis_top_test.sv ====
/*
 Self-checking bench for cis_top over APB: summaries, timer flag, irq, soft reset.
 Assumes read data lands one cycle after the access edge.
*/
`timescale 1ns/1ps
module cis_top_test;
	import cis_pkg::*;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] chan_irq_src;
	logic        timer_tick;
	logic [15:0] chan_soft_rst;
	logic [15:0] line_mode_select;
	logic        irq;
	logic [31:0] exp_q[$];
	logic        rd_seen;
	logic [15:0] seed;
	logic [15:0] mode;
	logic [11:0] a;
	int          miscompares;
	int          checks;
	int          n;

	cis_top #(.NCH(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.chan_irq_src(chan_irq_src), .timer_tick(timer_tick),
		.chan_soft_rst(chan_soft_rst), .line_mode_select(line_mode_select), .irq(irq));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic wrap_up();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Leading edge keeps an idle cycle so psel is never driven twice in one step
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
		input logic err);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (k >= 16) begin
			miscompares++;
			wrap_up();
		end
		chk({31'h0, pslverr}, {31'h0, err});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] ad, input logic [31:0] e, input logic err = 1'b0);
		exp_q.push_back(e);
		apb(1'b0, ad, 32'h0000_0000, err);
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge pclk);
		#1;
	endtask

	// Read data is compared one edge after its access edge
	always @(posedge pclk) begin
		if (rd_seen && exp_q.size() > 0) begin
			chk(prdata, exp_q.pop_front());
		end
		rd_seen <= psel && penable && pready && !pwrite;
	end

	initial begin
		{presetn, psel, penable, pwrite, timer_tick, rd_seen} = 6'h00;
		{paddr, pwdata, chan_irq_src, mode} = '0;
		{miscompares, checks} = '0;
		seed = 16'h2006;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(CIS_OFS_SUM_LOW, 32'h0000_0000);
		rd(CIS_OFS_TMR_STAT, 32'h0000_0000);
		$display("test reset_values done");
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			@(posedge pclk);
			chan_irq_src <= (i == 5) ? 16'hffff : seed;
			apb(1'b1, CIS_OFS_SUM_LOW, 32'hffff_ffff, 1'b0);
			rd(CIS_OFS_SUM_LOW, {24'h0, chan_irq_src[8:1]});
			rd(CIS_OFS_SUM_MID, {25'h0, chan_irq_src[15:9]});
			rd(CIS_OFS_SUM_ZERO, {24'h0, chan_irq_src[0], 7'h00});
		end
		$display("test summaries done");
		apb(1'b1, CIS_OFS_IRQ_EN, 32'h0000_0003, 1'b0);
		@(posedge pclk);
		timer_tick <= 1'b1;
		@(posedge pclk);
		timer_tick <= 1'b0;
		rd(CIS_OFS_TMR_STAT, 32'h0000_0001);
		rd(CIS_OFS_IRQ_STAT, 32'h0000_0001);
		tick(2);
		chk({31'h0, irq}, 32'h0000_0001);
		apb(1'b1, CIS_OFS_TMR_STAT, 32'h0000_0001, 1'b0);
		rd(CIS_OFS_TMR_STAT, 32'h0000_0000);
		apb(1'b1, CIS_OFS_IRQ_CLR, 32'h0000_0001, 1'b0);
		rd(CIS_OFS_IRQ_CLR, 32'h0000_0000);
		rd(CIS_OFS_IRQ_STAT, 32'h0000_0000);
		tick(2);
		chk({31'h0, irq}, 32'h0000_0000);
		$display("test timer done");
		foreach (seed[j]) begin
			if (j % 5 == 0) begin
				a = CIS_OFS_CFG_BASE + CIS_CFG_STRIDE * 12'(j);
				mode[j] = 1'b1;
				apb(1'b1, a, 32'h0000_0001, 1'b0);
				rd(a, 32'h0000_0001);
				apb(1'b1, a, 32'h0000_0003, 1'b0);
				#1;
				n = 0;
				while (chan_soft_rst === 16'h0000 && n < 4) begin
					tick(1);
					n++;
				end
				chk({16'h0, chan_soft_rst}, 32'h1 << j);
				chk({16'h0, line_mode_select}, {16'h0, mode});
				while (chan_soft_rst !== 16'h0000 && n < 40) begin
					tick(1);
					n++;
				end
				chk({31'h0, n <= 20}, 32'h0000_0001);
				rd(a, 32'h0000_0001);
				rd(CIS_OFS_IRQ_STAT, 32'h0000_0002);
				tick(2);
				chk({31'h0, irq}, 32'h0000_0001);
				apb(1'b1, CIS_OFS_IRQ_CLR, 32'h0000_0002, 1'b0);
			end
		end
		$display("test chan_reset done");
		rd(12'h0ffc, 32'h0000_0000, 1'b1);
		apb(1'b1, 12'h0ffc, 32'hffff_ffff, 1'b1);
		tick(3);
		$display("test unmapped done");
		wrap_up();
	end
endmodule // cis_top_test

// ==== inc/cis_pkg.sv ====
/*
 Constants for the channel interrupt summary and channel control block:
 register offsets, field positions, reset values and timing.
 Assumes a 20 MHz APB clock.
*/
package cis_pkg;

	localparam int          CIS_NUM_CHAN       = 16;
	localparam logic [11:0] CIS_OFS_SUM_LOW    = 12'h02c0;
	localparam logic [11:0] CIS_OFS_SUM_MID    = 12'h0300;
	localparam logic [11:0] CIS_OFS_SUM_ZERO   = 12'h0380;
	localparam logic [11:0] CIS_OFS_TMR_STAT   = 12'h03c0;
	// Channel n configuration sits at n*0x40 + 0x01, word aligned at n*0x40 + 0x04
	localparam logic [11:0] CIS_OFS_CFG_BASE   = 12'h0004;
	localparam logic [11:0] CIS_CFG_STRIDE     = 12'h0040;
	localparam logic [11:0] CIS_OFS_IRQ_EN     = 12'h0400;
	localparam logic [11:0] CIS_OFS_IRQ_CLR    = 12'h0404;
	localparam logic [11:0] CIS_OFS_IRQ_STAT   = 12'h0408;

	localparam int          CIS_BIT_TMR_OVF    = 0;
	localparam int          CIS_BIT_CH_RST     = 1;
	localparam int          CIS_BIT_LINE_MODE  = 0;
	localparam int          CIS_BIT_CH0_PEND   = 7;
	localparam logic [7:0]  CIS_RST_REG        = 8'h00;

	localparam int          CIS_CLK_HZ         = 20_000_000;
	localparam int          CIS_CH_RST_MAX_NS  = 1000;
	// Longest time rounds down
	localparam int          CIS_CH_RST_CYC     = (CIS_CH_RST_MAX_NS * (CIS_CLK_HZ / 1_000_000)) / 1000;
	localparam int          CIS_RST_HOLD_CYC   = 4;

	typedef enum logic [1:0] {
		CIS_RS_IDLE = 2'b00,
		CIS_RS_HOLD = 2'b01
	} cis_rst_state_t;

endpackage

// ==== rtl/cis_chan_reset.sv ====
/*
 Per-channel soft reset sequencer: one start pulse gives a reset pulse
 of a fixed length. Assumes the start pulse is one cycle wide.
*/
`timescale 1ns/1ps
module cis_chan_reset
	import cis_pkg::*;
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Control
	input  wire logic start,
	output logic      busy,
	output logic      done
);

	typedef struct packed {
		cis_rst_state_t st;
		logic [3:0]     cnt;
		logic           done;
	} cis_crs_t;

	cis_crs_t r;
	cis_crs_t next_r;

	always_comb begin
		next_r      = r;
		next_r.done = 1'b0;
		unique case (r.st)
			CIS_RS_IDLE: begin
				if (start) begin
					next_r.st  = CIS_RS_HOLD;
					next_r.cnt = 4'(CIS_RST_HOLD_CYC - 1);
				end
			end
			CIS_RS_HOLD: begin
				if (r.cnt == 4'h0) begin
					next_r.st   = CIS_RS_IDLE;
					next_r.done = 1'b1;
				end else begin
					next_r.cnt = r.cnt - 4'h1;
				end
			end
			default: next_r.st = CIS_RS_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign busy = (r.st == CIS_RS_HOLD);
	assign done = r.done;

endmodule // cis_chan_reset

// ==== rtl/cis_top.sv ====
/*
 Channel interrupt summary, one-second timer status and per-channel
 configuration, reached over APB. Channel interrupt sources, the timer
 tick and the channel datapaths are outside; chan_irq_src is a level
 per channel, timer_tick a one-cycle pulse.
*/
// The APB slave port was decided locally.
// Notes on behaviour
// - Summary low bits 7..0 show channels 8..1 pending.
// - A summary bit is one while any source of that channel is active.
// - Summary mid bits 6..0 show channels 15..9; bit 7 reads zero.
// - Summary zero bit 7 shows channel 0; bits 6..0 read zero.
// - Timer overflow flag sets on each one-second expiry.
// - Writing one clears the timer overflow flag; reset value zero.
// - A started channel reset completes within one microsecond.
// - The channel reset bit clears itself when the reset is done.
// - Config bit 0 picks line mode: zero 1.544, one 2.048 Mbit/s.
// - The line mode bit keeps its value through channel soft reset.
`timescale 1ns/1ps
module cis_top
	import cis_pkg::*;
#(
	parameter int NCH = CIS_NUM_CHAN
) (
	// APB
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Events
	input  wire logic [NCH-1:0] chan_irq_src,
	input  wire logic           timer_tick,
	// Channel control
	output logic [NCH-1:0]      chan_soft_rst,
	output logic [NCH-1:0]      line_mode_select,
	// Interrupt
	output logic                irq
);

	typedef struct packed {
		logic            second_timer_overflow_flag;
		logic [NCH-1:0]  line_mode;
		logic [NCH-1:0]  rst_req;
		logic [1:0]      irq_en;
		logic [1:0]      irq_stat;
		logic [NCH-1:0]  pend_q;
		logic [31:0]     rdata;
		logic            slverr;
	} cis_st_t;

	cis_st_t r;
	cis_st_t next_r;

	logic [NCH-1:0] rst_start;
	logic [NCH-1:0] rst_busy;
	logic [NCH-1:0] rst_done;

	logic acc;
	logic wr;
	logic rd;
	assign acc = psel & penable;
	assign wr  = acc & pwrite;
	assign rd  = acc & ~pwrite;

	function automatic int cfg_index(input logic [11:0] a);
		logic [11:0] off;
		off = a - CIS_OFS_CFG_BASE;
		if (a[5:0] == CIS_OFS_CFG_BASE[5:0] && int'(a[11:6]) < NCH)
			return int'(off[11:6]);
		return -1;
	endfunction

	function automatic logic [7:0] sum_low(input logic [NCH-1:0] p);
		return p[8:1];
	endfunction

	logic [7:0] w8;
	int         ci;
	always_comb begin
		next_r        = r;
		next_r.slverr = 1'b0;
		w8            = pwdata[7:0];
		ci            = cfg_index(paddr);
		rst_start     = '0;
		next_r.pend_q = chan_irq_src;

		// Channel reset bit drops once the sequencer finishes
		for (int i = 0; i < NCH; i++) begin
			if (rst_done[i])
				next_r.rst_req[i] = 1'b0;
		end

		if (rd) begin
			next_r.rdata = '0;
			if (paddr == CIS_OFS_SUM_LOW)
				next_r.rdata[7:0] = sum_low(r.pend_q);
			else if (paddr == CIS_OFS_SUM_MID)
				next_r.rdata[7:0] = {1'b0, r.pend_q[15:9]};
			else if (paddr == CIS_OFS_SUM_ZERO)
				next_r.rdata[CIS_BIT_CH0_PEND] = r.pend_q[0];
			else if (paddr == CIS_OFS_TMR_STAT)
				next_r.rdata[CIS_BIT_TMR_OVF] = r.second_timer_overflow_flag;
			else if (paddr == CIS_OFS_IRQ_EN)
				next_r.rdata[1:0] = r.irq_en;
			else if (paddr == CIS_OFS_IRQ_STAT)
				next_r.rdata[1:0] = r.irq_stat;
			else if (ci >= 0) begin
				next_r.rdata[CIS_BIT_CH_RST]    = r.rst_req[ci];
				next_r.rdata[CIS_BIT_LINE_MODE] = r.line_mode[ci];
			end else if (paddr != CIS_OFS_IRQ_CLR)
				next_r.slverr = 1'b1;
		end

		// Write one clears; a tick in the same cycle wins
		if (wr && paddr == CIS_OFS_TMR_STAT && w8[CIS_BIT_TMR_OVF])
			next_r.second_timer_overflow_flag = 1'b0;
		if (timer_tick)
			next_r.second_timer_overflow_flag = 1'b1;

		if (wr) begin
			if (paddr == CIS_OFS_IRQ_EN)
				next_r.irq_en = w8[1:0];
			else if (paddr == CIS_OFS_IRQ_CLR)
				next_r.irq_stat = r.irq_stat & ~w8[1:0];
			else if (ci >= 0) begin
				next_r.line_mode[ci] = w8[CIS_BIT_LINE_MODE];
				if (w8[CIS_BIT_CH_RST] && !r.rst_req[ci]) begin
					next_r.rst_req[ci] = 1'b1;
					rst_start[ci]      = 1'b1;
				end
			end else if (paddr == CIS_OFS_SUM_LOW || paddr == CIS_OFS_SUM_MID ||
			             paddr == CIS_OFS_SUM_ZERO || paddr == CIS_OFS_TMR_STAT ||
			             paddr == CIS_OFS_IRQ_STAT)
				next_r.slverr = 1'b0;
			else
				next_r.slverr = 1'b1;
		end

		// Sticky events: bit 0 timer, bit 1 reset done; set wins over clear
		if (timer_tick)
			next_r.irq_stat[0] = 1'b1;
		if (|rst_done)
			next_r.irq_stat[1] = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// One sequencer per channel keeps each reset independent
	for (genvar g = 0; g < NCH; g++) begin : g_rst
		cis_chan_reset u_rst (
			.pclk    (pclk),
			.presetn (presetn),
			.start   (rst_start[g]),
			.busy    (rst_busy[g]),
			.done    (rst_done[g])
		);
	end

	assign prdata           = r.rdata;
	assign pready           = 1'b1;
	assign pslverr          = acc & next_r.slverr;
	assign chan_soft_rst    = rst_busy;
	assign line_mode_select = r.line_mode;
	assign irq              = |(r.irq_stat & r.irq_en);

	// Assertions
	sequence s_rst_write(int k);
		wr && cfg_index(paddr) == k && pwdata[CIS_BIT_CH_RST] && !r.rst_req[k];
	endsequence

	property p_sum_low;
		@(posedge pclk) disable iff (!presetn)
		1 |=> sum_low(r.pend_q) == $past(chan_irq_src[8:1]);
	endproperty
	a_sum_low: assert property (p_sum_low) else $error("summary low wrong");

	property p_pend;
		@(posedge pclk) disable iff (!presetn)
		chan_irq_src == '0 |=> r.pend_q == '0;
	endproperty
	a_pend: assert property (p_pend) else $error("pending not cleared");

	property p_mid_rsvd;
		@(posedge pclk) disable iff (!presetn)
		rd && paddr == CIS_OFS_SUM_MID |=> prdata[7] == 1'b0 && prdata[6:0] == $past(r.pend_q[15:9]);
	endproperty
	a_mid_rsvd: assert property (p_mid_rsvd) else $error("summary mid wrong");

	property p_zero;
		@(posedge pclk) disable iff (!presetn)
		rd && paddr == CIS_OFS_SUM_ZERO |=> prdata[6:0] == 7'h00 && prdata[7] == $past(r.pend_q[0]);
	endproperty
	a_zero: assert property (p_zero) else $error("summary zero wrong");

	property p_tmr_set;
		@(posedge pclk) disable iff (!presetn)
		timer_tick |=> r.second_timer_overflow_flag;
	endproperty
	a_tmr_set: assert property (p_tmr_set) else $error("timer flag not set");

	property p_tmr_clr;
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == CIS_OFS_TMR_STAT && pwdata[0] && !timer_tick |=> !r.second_timer_overflow_flag;
	endproperty
	a_tmr_clr: assert property (p_tmr_clr) else $error("timer flag not cleared");

	property p_rst_start;
		@(posedge pclk) disable iff (!presetn)
		s_rst_write(0) |=> r.rst_req[0] && chan_soft_rst[0];
	endproperty
	a_rst_start: assert property (p_rst_start) else $error("reset not started");

	property p_rst_done;
		@(posedge pclk) disable iff (!presetn)
		s_rst_write(0) |=> ##[1:19] !r.rst_req[0];
	endproperty
	a_rst_done: assert property (p_rst_done) else $error("reset over 1 us");

	property p_self_clr;
		@(posedge pclk) disable iff (!presetn)
		rst_done[0] |=> !r.rst_req[0] && !chan_soft_rst[0];
	endproperty
	a_self_clr: assert property (p_self_clr) else $error("reset bit stuck");

	property p_mode_keep;
		@(posedge pclk) disable iff (!presetn)
		chan_soft_rst[0] && !(wr && cfg_index(paddr) == 0) |=> $stable(line_mode_select[0]);
	endproperty
	a_mode_keep: assert property (p_mode_keep) else $error("mode lost");

	property p_isolate;
		@(posedge pclk) disable iff (!presetn)
		s_rst_write(0) |=> chan_soft_rst[NCH-1:1] == $past(chan_soft_rst[NCH-1:1]);
	endproperty
	a_isolate: assert property (p_isolate) else $error("reset leaked");

	property p_mode_wr;
		@(posedge pclk) disable iff (!presetn)
		wr && cfg_index(paddr) == 0 |=> line_mode_select[0] == $past(pwdata[0]);
	endproperty
	a_mode_wr: assert property (p_mode_wr) else $error("mode not written");

	// Read-back checks for summary low and timer status, upper bits included; summary mid and zero pending tracking
	property p_low_rd;
		@(posedge pclk) disable iff (!presetn)
		rd && paddr == CIS_OFS_SUM_LOW |=> prdata[7:0] == $past(r.pend_q[8:1]) && prdata[31:8] == '0;
	endproperty
	a_low_rd: assert property (p_low_rd) else $error("summary low read wrong");

	property p_mid_pend;
		@(posedge pclk) disable iff (!presetn)
		1 |=> r.pend_q[15:9] == $past(chan_irq_src[15:9]);
	endproperty
	a_mid_pend: assert property (p_mid_pend) else $error("summary mid not tracking");

	property p_zero_pend;
		@(posedge pclk) disable iff (!presetn)
		1 |=> r.pend_q[0] == $past(chan_irq_src[0]);
	endproperty
	a_zero_pend: assert property (p_zero_pend) else $error("summary zero not tracking");

	property p_tmr_rd;
		@(posedge pclk) disable iff (!presetn)
		rd && paddr == CIS_OFS_TMR_STAT |=>
			prdata[0] == $past(r.second_timer_overflow_flag) && prdata[31:1] == '0;
	endproperty
	a_tmr_rd: assert property (p_tmr_rd) else $error("timer status read wrong");

	// The flag only moves on a tick or a clearing write
	property p_tmr_hold;
		@(posedge pclk) disable iff (!presetn)
		!timer_tick && !(wr && paddr == CIS_OFS_TMR_STAT) |=> $stable(r.second_timer_overflow_flag);
	endproperty
	a_tmr_hold: assert property (p_tmr_hold) else $error("timer flag moved");

	property p_tmr_win;
		@(posedge pclk) disable iff (!presetn)
		timer_tick && wr && paddr == CIS_OFS_TMR_STAT |=> r.second_timer_overflow_flag;
	endproperty
	a_tmr_win: assert property (p_tmr_win) else $error("clear beat tick");

	property p_tick_stat;
		@(posedge pclk) disable iff (!presetn)
		timer_tick |=> r.irq_stat[0];
	endproperty
	a_tick_stat: assert property (p_tick_stat) else $error("tick status missing");

	property p_irq_clr;
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == CIS_OFS_IRQ_CLR && pwdata[0] && !timer_tick |=> !r.irq_stat[0];
	endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("tick status not cleared");

	// Pulse length is fixed, so the bound holds with margin
	property p_rst_len;
		@(posedge pclk) disable iff (!presetn)
		s_rst_write(0) |=> chan_soft_rst[0] [*4] ##1 !chan_soft_rst[0];
	endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset pulse length");

	property p_rst_bit;
		@(posedge pclk) disable iff (!presetn)
		s_rst_write(0) |=> r.rst_req[0] [*5] ##1 !r.rst_req[0];
	endproperty
	a_rst_bit: assert property (p_rst_bit) else $error("reset bit timing");

	property p_rst_stat;
		@(posedge pclk) disable iff (!presetn)
		rst_done[0] |=> r.irq_stat[1];
	endproperty
	a_rst_stat: assert property (p_rst_stat) else $error("reset done status missing");

	property p_cfg_rd;
		@(posedge pclk) disable iff (!presetn)
		rd && cfg_index(paddr) == 0 |=> prdata[31:2] == '0 &&
			prdata[1:0] == {$past(r.rst_req[0]), $past(r.line_mode[0])};
	endproperty
	a_cfg_rd: assert property (p_cfg_rd) else $error("config read wrong");

	property p_mode_only_wr;
		@(posedge pclk) disable iff (!presetn)
		!(wr && cfg_index(paddr) == 0) |=> $stable(line_mode_select[0]);
	endproperty
	a_mode_only_wr: assert property (p_mode_only_wr) else $error("mode changed");

	// A reset of one channel must leave every line mode alone
	property p_rst_modes;
		@(posedge pclk) disable iff (!presetn)
		s_rst_write(5) |=> chan_soft_rst[5] && line_mode_select == $past(line_mode_select);
	endproperty
	a_rst_modes: assert property (p_rst_modes) else $error("reset touched modes");

endmodule // cis_top
